/* verif/page_mode_dram_cycle_refresh_test.sv */
// Self-checking bench for the page-mode memory controller
`timescale 1ns/1ps
`default_nettype none
module page_mode_dram_cycle_refresh_test;
   localparam int INIT = 20;
   localparam int REF = 40;
   localparam int D = 2;
   logic mclk = 0, reset_n = 0, req_valid = 0, req_write = 0, req_rmw = 0, rd_ready = 0, sr_req = 0;
   logic [1:0] req_be = 2'h3;
   logic [15:0] req_addr = 16'h0000;
   logic [17:0] req_wdata = 18'h00000, rd_data, dq_in, dq_out, ex;
   logic req_ready, rd_valid, sr_active, init_done, ras_n, lo_n, hi_n, we_n, oe_n, dq_oe, pcl = 0, pg = 0;
   logic [7:0] dram_addr;
   int n_mismatch = 0, samples_checked = 0, n_ref, cyc = 0, ras_lo = 0, ras_hi = 0, first_ras = -1, gap = 0;
   int sr_lo = 0, sr_hi = 0, sr_exit = 0, n0;
   pmd_ctrl #(.INIT_CYC(INIT), .REF_INT_CYC(REF)) pmd_ctrl_inst (.mclk(mclk), .reset_n(reset_n),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_rmw(req_rmw), .req_be(req_be),
      .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
      .sr_req(sr_req), .sr_active(sr_active), .init_done(init_done), .ras_n(ras_n),
      .low_byte_column_strobe_n(lo_n), .high_byte_column_strobe_n(hi_n), .we_n(we_n), .oe_n(oe_n),
      .dram_addr(dram_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
   pmd_mem_model pmd_mem_model_inst (.ras_n(ras_n), .lo_cas_n(lo_n), .hi_cas_n(hi_n), .we_n(we_n), .oe_n(oe_n),
      .addr(dram_addr), .d(dq_out), .d_en(dq_oe), .q(dq_in), .n_refresh(n_ref));
   initial forever #50 mclk = ~mclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Bounded wait on one completion flag; running out ends the run
   task automatic wait_for(input int sel, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge mclk);
         if ((sel == 0 && init_done === 1) || (sel == 1 && req_ready === 1) || (sel == 2 && rd_valid === 1)
            || (sel == 3 && sr_active === 1) || (sel == 4 && sr_active === 0)) break;
      end
      if (i == lim) begin
         check(sel, 32'hFF);
         end_of_test();
      end
   endtask
   task automatic req(input logic w, input logic m, input logic [1:0] be, input logic [15:0] ad,
                      input logic [17:0] wd);
      @(posedge mclk);
      #D {req_write, req_rmw, req_be, req_addr, req_wdata} = {w, m, be, ad, wd};
      req_valid = 1;
      wait_for(1, 3000);
      #D req_valid = 0;
   endtask
   task automatic take(input logic [17:0] exp);
      @(posedge mclk);
      #D rd_ready = 1;
      wait_for(2, 100);
      check(rd_data, exp);
      #D rd_ready = 0;
   endtask
   // Strobe watch, sampled mid-cycle where registered pins have settled
   always @(negedge mclk) if (reset_n) begin
      cyc++;
      if (!ras_n && first_ras < 0) first_ras = cyc;
      if (ras_n) begin
         if (ras_lo > 0) begin
            check(pcl, 0);
            if (!sr_active) check(ras_lo <= 1000, 1);
            if (ras_lo > 900) {sr_lo, sr_exit} = {ras_lo, 1};
         end
         {ras_lo, pg} = {0, 1'b0};
         ras_hi++;
      end else begin
         if (ras_lo == 0 && sr_exit) {sr_hi, sr_exit} = {ras_hi, 0};
         {ras_hi, ras_lo} = {0, ras_lo + 1};
         if (!(lo_n & hi_n) && !pcl) begin
            if (pg) check(gap >= 2, 1);
            {gap, pg} = {0, 1'b1};
         end
      end
      gap++;
      pcl = !(lo_n & hi_n);
   end
   task automatic t_init();
      wait_for(0, INIT + 400);
      check(n_ref, 8);
      check(first_ras > INIT, 1);
   endtask
   // Byte-masked early writes within one page, each read back at once
   task automatic t_rw();
      logic [1:0] be [3] = '{2'h3, 2'h1, 2'h2};
      logic [17:0] wd [3] = '{18'h12345, 18'h2AAAA, 18'h3C0F0};
      ex = 18'h00000;
      for (int i = 0; i < 3; i++) begin
         req(1, 0, be[i], 16'h2A10, wd[i]);
         if (be[i][0]) ex[8:0] = wd[i][8:0];
         if (be[i][1]) ex[17:9] = wd[i][17:9];
         req(0, 0, 2'h3, 16'h2A10, 18'h00000);
         take(ex);
      end
   endtask
   task automatic t_rmw();
      req(0, 1, 2'h3, 16'h2A10, 18'h0BEEF);
      take(ex);
      req(0, 0, 2'h3, 16'h2A10, 18'h00000);
      take(18'h0BEEF);
   endtask
   // Receiver stalls: two words fill the buffer, the third read waits, none is lost
   task automatic t_stall();
      for (int i = 0; i < 3; i++) req(1, 0, 2'h3, 16'h5520 + i, 18'h00100 + i);
      fork
         for (int i = 0; i < 3; i++) req(0, 0, 2'h3, 16'h5520 + i, 18'h00000);
         begin
            repeat (30) @(posedge mclk);
            @(negedge mclk);
            check({rd_valid, req_ready}, 2'h2);
            for (int i = 0; i < 3; i++) take(18'h00100 + i);
         end
      join
      @(negedge mclk);
      check(rd_valid, 0);
   endtask
   task automatic t_ref();
      n0 = n_ref;
      repeat (10 * REF) @(posedge mclk);
      check(n_ref - n0 >= 9 && n_ref - n0 <= 11, 1);
   endtask
   // Self-refresh asked briefly: row stays low the full minimum, then burst refresh
   task automatic t_sr();
      @(posedge mclk);
      #D sr_req = 1;
      wait_for(3, 2000);
      repeat (100) @(posedge mclk);
      #D sr_req = 0;
      wait_for(4, 3000);
      n0 = n_ref;
      repeat (2000) @(posedge mclk);
      check(sr_lo >= 1000, 1);
      check(sr_hi >= 2, 1);
      check(n_ref - n0 >= 256, 1);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      #D reset_n = 1;
      @(negedge mclk);
      check({ras_n, lo_n, hi_n, we_n, oe_n, dq_oe, init_done}, 7'h7C);
      t_init();
      t_rw();
      t_rmw();
      t_stall();
      t_ref();
      t_sr();
      end_of_test();
   end
endmodule
`default_nettype wire

/* verif/pmd_mem_model.sv */
// Behavioural model of the page-mode memory facing the controller
`timescale 1ns/1ps
`default_nettype none
module pmd_mem_model (
   input wire logic ras_n,      // Row strobe
   input wire logic lo_cas_n,   // Low byte column strobe
   input wire logic hi_cas_n,   // High byte column strobe
   input wire logic we_n,       // Write strobe
   input wire logic oe_n,       // Output gate
   input wire logic [7:0] addr, // Multiplexed address
   input wire logic [17:0] d,   // Data from controller
   input wire logic d_en,       // Controller drives data
   output logic [17:0] q,       // Data to controller
   output int n_refresh         // Column-first refreshes seen
);
   logic [17:0] mem [0:65535];
   logic [7:0] row;
   logic [15:0] a;
   logic [1:0] cs;
   logic wr_done = 1'b0;
   logic garbled = 1'b0;
   logic drv;
   logic [17:0] last = 18'h00000;
   assign cs = {~hi_cas_n, ~lo_cas_n};
   assign drv = !ras_n && cs != 2'h0 && !oe_n && we_n && !wr_done;
   initial n_refresh = 0;
   // Undriven data lines only carry data when the controller enables them
   task automatic write_word();
      if (cs[0]) mem[a][8:0] = d_en ? d[8:0] : 'x;
      if (cs[1]) mem[a][17:9] = d_en ? d[17:9] : 'x;
      wr_done = 1'b1;
   endtask
   // Row fall with a column strobe already low is a refresh; one byte strobe suffices
   always @(negedge ras_n) #1 begin
      if (cs != 2'h0) n_refresh = n_refresh + 1;
      else row = addr;
   end
   // Write strobe already low at column fall is an early write, data pins stay undriven
   always @(negedge lo_cas_n or negedge hi_cas_n) #1 begin
      if (!ras_n) begin
         a = {row, addr};
         wr_done = 1'b0;
         garbled = 1'b0;
         if (!we_n) write_word();
      end
   end
   // Late write strobe: read-modify-write, or delayed write if the gate is still low
   // Runs after the column block, so an early write never lands on the old address
   always @(negedge we_n) #2 begin
      if (!ras_n && cs != 2'h0 && !wr_done) begin
         garbled = !oe_n;
         write_word();
      end
   end
   // Released lines show the inverse of the last word so stale data never matches
   always @* begin
      if (drv) q = mem[a];
      else if (garbled && !oe_n && cs != 2'h0) q = 'x;
      else q = ~last;
   end
   always @(q) if (drv) last = q;
endmodule
`default_nettype wire

/* verilog/pmd_buf_if.sv */
// Fill side of the read data buffer
`timescale 1ns/1ps
`default_nettype none
interface pmd_buf_if #(parameter int W = 18);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   modport fill (output in_valid, output in_data, input in_ready);
   modport store (input in_valid, input in_data, output in_ready);
endinterface
`default_nettype wire

/* verilog/pmd_ctrl.sv */
// Host-side controller for a 64K x 18 page-mode dynamic memory
`timescale 1ns/1ps
`default_nettype none
`include "pmd_defines.svh"
module pmd_ctrl #(
   parameter int INIT_CYC = `PMD_INIT_CYC,        // Power-up pause in cycles
   parameter int REF_INT_CYC = `PMD_REF_INT_CYC,  // Cycles between row refreshes
   parameter bit SLOW_GRADE = 1'b1                // Slower speed grade timings
) (
   input wire logic mclk,                              // 10 MHz clock
   input wire logic reset_n,                           // Synchronous reset
   input wire logic req_valid,                         // Access request
   output logic req_ready,                             // Request taken
   input wire logic req_write,                         // Write access
   input wire logic req_rmw,                           // Read then write same word
   input wire logic [1:0] req_be,                      // Byte enables, bit 1 high byte
   input wire logic [15:0] req_addr,                   // Row in upper byte
   input wire logic [`PMD_DATA_BITS-1:0] req_wdata,    // Write data
   output logic rd_valid,                              // Read word available
   input wire logic rd_ready,                          // Receiver takes word
   output logic [`PMD_DATA_BITS-1:0] rd_data,          // Read word
   input wire logic sr_req,                            // Hold memory in self-refresh
   output logic sr_active,                             // Self-refresh in progress
   output logic init_done,                             // Memory ready for use
   output logic ras_n,                                 // Row strobe
   output logic low_byte_column_strobe_n,              // Low byte column strobe
   output logic high_byte_column_strobe_n,             // High byte column strobe
   output logic we_n,                                  // Write strobe
   output logic oe_n,                                  // Output gate
   output logic [`PMD_ROW_BITS-1:0] dram_addr,         // Multiplexed address
   input wire logic [`PMD_DATA_BITS-1:0] dq_in,        // Data pins in
   output logic [`PMD_DATA_BITS-1:0] dq_out,           // Data pins out
   output logic dq_oe                                  // Data pins driven
);
   localparam int RPS_CYC = `PMD_CEIL_CYC(SLOW_GRADE ? `PMD_T_RPS_SLOW_NS : `PMD_T_RPS_FAST_NS);
   localparam int RAS_MIN_CYC =
      `PMD_CEIL_CYC(SLOW_GRADE ? `PMD_T_RAS_PAGE_MIN_SLOW_NS : `PMD_T_RAS_PAGE_MIN_FAST_NS);
   localparam int PAGE_MAX_CYC = `PMD_RAS_PAGE_MAX_CYC;
   localparam int RASS_CYC = `PMD_RASS_CYC;
   localparam int PC_CYC = `PMD_CEIL_CYC(`PMD_T_PC_SLOW_NS);
   localparam int PRWC_CYC = `PMD_CEIL_CYC(`PMD_T_PRWC_SLOW_NS);

   pmd_pkg::pmd_state_e state;
   pmd_pkg::pmd_state_e next_state;
   logic [12:0] cnt;
   logic [13:0] ras_cnt;
   logic [7:0] col_gap;
   logic [7:0] ref_tick;
   logic [2:0] ref_pend;
   logic [8:0] burst;
   logic [15:0] cur_addr;
   logic cur_write;
   logic cur_rmw;
   logic [1:0] cur_be;
   logic [`PMD_DATA_BITS-1:0] cur_wdata;
   logic accept;
   logic ref_need;
   logic page_hit;
   logic take_ok;
   logic tick;
   logic ref_done;
   logic [15:0] next_addr;
   logic next_write;
   logic next_rmw;
   logic [1:0] next_be;
   logic cas_any_n;

   pmd_buf_if #(.W(`PMD_DATA_BITS)) rbuf ();

   // Read words wait here so that a stalled receiver loses none
   pmd_rd_buf #(.W(`PMD_DATA_BITS), .DEPTH(2)) u_rd_buf (
      .mclk(mclk),
      .reset_n(reset_n),
      .fill(rbuf.store),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   // A read is only started when the buffer has room for its word
   assign take_ok = req_valid && (req_write && !req_rmw || rbuf.in_ready);
   assign ref_need = (ref_pend != '0) || (burst != '0);
   assign page_hit = take_ok && (req_addr[15:8] == cur_addr[15:8]) && !ref_need && !sr_req
      && (ras_cnt < 14'(PAGE_MAX_CYC - 8));
   assign accept = (state == pmd_pkg::PMD_IDLE && !ref_need && !sr_req && take_ok)
      || (state == pmd_pkg::PMD_PCHG && page_hit);
   assign req_ready = accept;
   assign rbuf.in_valid = (state == pmd_pkg::PMD_COL) && (!cur_write || cur_rmw);
   assign rbuf.in_data = dq_in;
   assign cas_any_n = low_byte_column_strobe_n && high_byte_column_strobe_n;
   assign tick = (ref_tick == 8'(REF_INT_CYC - 1));
   assign ref_done = (next_state == pmd_pkg::PMD_REF_RAS);
   assign next_addr = accept ? req_addr : cur_addr;
   assign next_write = accept ? req_write : cur_write;
   assign next_rmw = accept ? req_rmw : cur_rmw;
   assign next_be = accept ? req_be : cur_be;

   // Sequencer; refresh outranks accesses, self-refresh waits for the burst
   always_comb begin
      next_state = state;
      unique case (state)
         pmd_pkg::PMD_INIT: if (cnt == 13'(INIT_CYC - 1)) next_state = pmd_pkg::PMD_REF_CAS;
         pmd_pkg::PMD_IDLE: begin
            if (ref_need) begin
               next_state = pmd_pkg::PMD_REF_CAS; // Never hidden behind an access
            end else if (sr_req) begin
               next_state = pmd_pkg::PMD_SR_CAS;
            end else if (accept) begin
               next_state = pmd_pkg::PMD_ROW;
            end
         end
         pmd_pkg::PMD_ROW: next_state = pmd_pkg::PMD_COL;
         pmd_pkg::PMD_COL: next_state = cur_rmw ? pmd_pkg::PMD_RMW_TURN : pmd_pkg::PMD_PCHG;
         pmd_pkg::PMD_RMW_TURN: next_state = pmd_pkg::PMD_RMW_WR;
         pmd_pkg::PMD_RMW_WR: next_state = pmd_pkg::PMD_PCHG;
         pmd_pkg::PMD_PCHG: next_state = page_hit ? pmd_pkg::PMD_COL : pmd_pkg::PMD_RAS_UP;
         pmd_pkg::PMD_RAS_UP: next_state = pmd_pkg::PMD_IDLE;
         pmd_pkg::PMD_REF_CAS: next_state = pmd_pkg::PMD_REF_RAS;
         pmd_pkg::PMD_REF_RAS: next_state = pmd_pkg::PMD_REF_HOLD;
         pmd_pkg::PMD_REF_HOLD: next_state = pmd_pkg::PMD_RAS_UP;
         pmd_pkg::PMD_SR_CAS: next_state = pmd_pkg::PMD_SR_RAS;
         pmd_pkg::PMD_SR_RAS: next_state = pmd_pkg::PMD_SR_HOLD;
         pmd_pkg::PMD_SR_HOLD: begin
            if (!sr_req && cnt >= 13'(RASS_CYC)) next_state = pmd_pkg::PMD_SR_EXIT;
         end
         pmd_pkg::PMD_SR_EXIT: if (cnt == 13'(RPS_CYC - 1)) next_state = pmd_pkg::PMD_IDLE;
         default: next_state = pmd_pkg::PMD_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state <= pmd_pkg::PMD_INIT;
      end else begin
         state <= next_state;
      end
   end

   // Dwell counter restarts on every state change
   always_ff @(posedge mclk) begin
      if (!reset_n || next_state != state) begin
         cnt <= '0;
      end else if (cnt != '1) begin
         cnt <= cnt + 1'b1;
      end
   end

   // Row and column strobe age; bounds page bursts and proves spacing
   always_ff @(posedge mclk) begin
      if (!reset_n || ras_n) begin
         ras_cnt <= '0;
      end else if (ras_cnt != '1) begin
         ras_cnt <= ras_cnt + 1'b1;
      end
      if (!reset_n || (!cas_any_n && $past(cas_any_n))) begin
         col_gap <= '0;
      end else if (col_gap != '1) begin
         col_gap <= col_gap + 1'b1;
      end
   end

   // Interval counter; a tick in the same cycle as a refresh is not lost
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ref_tick <= '0;
         ref_pend <= '0;
      end else if (sr_active || state == pmd_pkg::PMD_INIT) begin
         ref_tick <= '0; // Memory refreshes itself or is not yet in use
         ref_pend <= '0;
      end else begin
         ref_tick <= tick ? '0 : ref_tick + 1'b1;
         if (tick && !(ref_done && ref_pend != '0) && ref_pend != 3'(`PMD_PEND_MAX)) begin
            ref_pend <= ref_pend + 1'b1;
         end else if (!tick && ref_done && ref_pend != '0) begin
            // Burst refreshes pay off due ticks too, else the backlog overflows
            ref_pend <= ref_pend - 1'b1;
         end
      end
   end

   // Refresh bursts: eight at start-up, all rows after self-refresh exit
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         burst <= '0;
         init_done <= 1'b0;
      end else begin
         if (state == pmd_pkg::PMD_INIT && next_state != state) begin
            burst <= 9'(`PMD_INIT_REFS);
         end else if (state == pmd_pkg::PMD_SR_EXIT && next_state != state) begin
            burst <= 9'(`PMD_ROWS);
         end else if (ref_done && burst != '0) begin
            burst <= burst - 1'b1;
         end
         if (state == pmd_pkg::PMD_IDLE && burst == '0) begin
            init_done <= 1'b1;
         end
      end
   end

   // Request latch; only refreshed when a request is taken
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cur_addr <= '0;
         cur_write <= 1'b0;
         cur_rmw <= 1'b0;
         cur_be <= '0;
         cur_wdata <= '0;
      end else if (accept) begin
         cur_addr <= req_addr;
         cur_write <= req_write;
         cur_rmw <= req_rmw;
         cur_be <= req_be;
         cur_wdata <= req_wdata;
      end
   end

   // Pins registered from the next state so strobes never glitch
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ras_n <= 1'b1;
         low_byte_column_strobe_n <= 1'b1;
         high_byte_column_strobe_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         dram_addr <= '0;
         dq_out <= '0;
         dq_oe <= 1'b0;
         sr_active <= 1'b0;
      end else begin
         ras_n <= !(next_state inside {pmd_pkg::PMD_ROW, pmd_pkg::PMD_COL, pmd_pkg::PMD_PCHG,
            pmd_pkg::PMD_RMW_TURN, pmd_pkg::PMD_RMW_WR, pmd_pkg::PMD_REF_RAS, pmd_pkg::PMD_REF_HOLD,
            pmd_pkg::PMD_SR_RAS, pmd_pkg::PMD_SR_HOLD});
         // Refresh uses both byte strobes; the memory also takes either alone
         if (next_state inside {pmd_pkg::PMD_REF_CAS, pmd_pkg::PMD_REF_RAS,
            pmd_pkg::PMD_SR_CAS, pmd_pkg::PMD_SR_RAS}) begin
            low_byte_column_strobe_n <= 1'b0;
            high_byte_column_strobe_n <= 1'b0;
         end else if (next_state inside {pmd_pkg::PMD_COL, pmd_pkg::PMD_RMW_TURN, pmd_pkg::PMD_RMW_WR}) begin
            low_byte_column_strobe_n <= !next_be[0];
            high_byte_column_strobe_n <= !next_be[1];
         end else begin
            low_byte_column_strobe_n <= 1'b1;
            high_byte_column_strobe_n <= 1'b1;
         end
         // Plain writes are early, read-modify-write writes late after the gate is released, so the data pins never go undefined
         we_n <= !((next_state == pmd_pkg::PMD_COL && next_write && !next_rmw)
            || next_state == pmd_pkg::PMD_RMW_WR);
         oe_n <= !(next_state == pmd_pkg::PMD_COL && (!next_write || next_rmw));
         dq_oe <= (next_state == pmd_pkg::PMD_COL && next_write && !next_rmw)
            || next_state == pmd_pkg::PMD_RMW_WR;
         dq_out <= accept ? req_wdata : cur_wdata;
         dram_addr <= (next_state == pmd_pkg::PMD_ROW) ? next_addr[15:8] : next_addr[7:0];
         sr_active <= next_state inside {pmd_pkg::PMD_SR_CAS, pmd_pkg::PMD_SR_RAS,
            pmd_pkg::PMD_SR_HOLD, pmd_pkg::PMD_SR_EXIT};
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence s_cbr_start;
      $fell(ras_n) && !cas_any_n;
   endsequence
   sequence s_rmw_steps;
      !oe_n && we_n && !dq_oe ##1 oe_n && we_n && !dq_oe ##1 !we_n && dq_oe && !cas_any_n;
   endsequence
   sequence s_sr_leave;
      $rose(ras_n) && sr_active;
   endsequence

   a_page_ras_max: assert property (!sr_active |-> ras_cnt < 14'(PAGE_MAX_CYC))
      else $error("row strobe low too long in page burst");
   a_ras_min_low: assert property ($rose(ras_n) |-> $past(ras_cnt) >= 14'(RAS_MIN_CYC - 1))
      else $error("row strobe low pulse too short");
   a_page_spacing: assert property ($fell(cas_any_n) && !ras_n && !$fell(ras_n)
      |-> col_gap >= 8'(PC_CYC))
      else $error("page column cycles too close");
   a_rmw_order: assert property (state == pmd_pkg::PMD_COL && cur_rmw |-> s_rmw_steps
      ##1 cas_any_n && !ras_n && col_gap >= 8'(PRWC_CYC))
      else $error("read-modify-write steps out of order");
   a_cas_before_ras: assert property ($rose(ras_n) |-> $past(cas_any_n))
      else $error("row released before column precharge");
   a_cbr_setup: assert property (s_cbr_start |-> $past(!cas_any_n) && $past(ras_n))
      else $error("column-first refresh setup missing");
   a_early_write: assert property ($fell(cas_any_n) && !we_n |-> dq_oe && oe_n)
      else $error("write not started as early write");
   a_sr_hold_min: assert property (s_sr_leave |-> $past(ras_cnt) >= 14'(RASS_CYC))
      else $error("self-refresh left too early");
   a_sr_exit_rps: assert property (s_sr_leave |-> ras_n[*2])
      else $error("row precharge after self-refresh too short");
   a_sr_burst: assert property (state == pmd_pkg::PMD_SR_EXIT && next_state == pmd_pkg::PMD_IDLE
      |=> burst == 9'(`PMD_ROWS) ##1 state == pmd_pkg::PMD_REF_CAS)
      else $error("refresh burst not started after self-refresh");
   a_ref_pend: assert property (ref_pend < 3'(`PMD_PEND_MAX))
      else $error("refresh backlog too deep");
   a_init_first: assert property (state == pmd_pkg::PMD_ROW |-> init_done)
      else $error("access before start-up refresh done");
endmodule
`default_nettype wire

/* verilog/pmd_defines.svh */
// Timing counts and geometry constants for the page-mode memory controller
`ifndef PMD_DEFINES_SVH
`define PMD_DEFINES_SVH

`define PMD_CLK_NS 100
`define PMD_ROW_BITS 8
`define PMD_DATA_BITS 18
`define PMD_ROWS 256
`define PMD_INIT_REFS 8
`define PMD_T_INIT_US 500
`define PMD_INIT_CYC ((`PMD_T_INIT_US * 1000 + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_T_REF_NS 4000000
`define PMD_REF_INT_CYC (`PMD_T_REF_NS / `PMD_ROWS / `PMD_CLK_NS)
`define PMD_T_RAS_PAGE_MAX_NS 100000
`define PMD_RAS_PAGE_MAX_CYC (`PMD_T_RAS_PAGE_MAX_NS / `PMD_CLK_NS)
`define PMD_T_RASS_US 100
`define PMD_RASS_CYC ((`PMD_T_RASS_US * 1000 + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_T_RPS_FAST_NS 110
`define PMD_T_RPS_SLOW_NS 135
`define PMD_T_RAS_PAGE_MIN_FAST_NS 100
`define PMD_T_RAS_PAGE_MIN_SLOW_NS 130
`define PMD_T_PC_SLOW_NS 50
`define PMD_T_PRWC_SLOW_NS 100
`define PMD_CEIL_CYC(ns) (((ns) + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_PEND_MAX 7

`endif

/* verilog/pmd_pkg.sv */
// Types shared by the page-mode memory controller
`default_nettype none
package pmd_pkg;
   // Gray codes along idle, row, column, precharge, row release
   typedef enum logic [3:0] {
      PMD_IDLE     = 4'h0,
      PMD_ROW      = 4'h1,
      PMD_COL      = 4'h3,
      PMD_PCHG     = 4'h2,
      PMD_RAS_UP   = 4'h6,
      PMD_RMW_TURN = 4'h7,
      PMD_RMW_WR   = 4'h5,
      PMD_REF_CAS  = 4'h4,
      PMD_REF_RAS  = 4'hC,
      PMD_REF_HOLD = 4'hD,
      PMD_SR_CAS   = 4'hF,
      PMD_SR_RAS   = 4'hE,
      PMD_SR_HOLD  = 4'hA,
      PMD_SR_EXIT  = 4'hB,
      PMD_INIT     = 4'h9
   } pmd_state_e;
endpackage
`default_nettype wire

/* verilog/pmd_rd_buf.sv */
// Two-entry read data buffer between memory and receiver
`timescale 1ns/1ps
`default_nettype none
module pmd_rd_buf #(
   parameter int W = 18,
   parameter int DEPTH = 2
) (
   input wire logic mclk,          // System clock
   input wire logic reset_n,       // Synchronous reset
   pmd_buf_if.store fill,          // Write side
   output logic out_valid,         // Word available
   input wire logic out_ready,     // Receiver takes word
   output logic [W-1:0] out_data   // Oldest word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Honest full and empty from the occupancy count
   assign fill.in_ready = (count < (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = fill.in_valid && fill.in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   // Storage is written only on push, so it needs no reset
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= fill.in_data;
      end
   end

   // Pointers wrap at the configured depth
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire
